// ---- rtl/srre_exec.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "srre_params.svh"

// Notes on behaviour
// - subroutine return pops the stack and loads the popped top into the pc
// - fast-return bit set: restore accumulator, flags and bank select from shadows
// - fast-return bit clear: accumulator, flags and bank select stay as they are
// - return leaves pc latches alone and touches flags only via shadow restore
// - rotate left through carry: bit 7 to carry, carry to bit 0, set C N Z
// - destination bit 0 writes the accumulator, 1 writes back the file register
// - access bit 0 uses access bank, 1 uses bank select register
// - access 0, extended set on, address up to 95: indexed literal offset mode
// - return with literal loads accumulator from literal and pops into pc
module srre_exec
    import srre_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic [15:0] instr_word,
    input wire logic ext_set_en,
    input wire logic [11:0] index_base,
    input wire logic [20:0] stack_top,
    input wire logic [7:0] accumulator_shadow,
    input wire logic [4:0] flags_shadow,
    input wire logic [3:0] bank_select_shadow,
    output logic [11:0] file_raddr,
    input wire logic [7:0] file_rdata,
    output logic file_we,
    output logic [11:0] file_waddr,
    output logic [7:0] file_wdata,
    output logic stack_pop,
    output logic pc_load,
    output logic [20:0] pc_target,
    output logic [7:0] acc,
    output logic [4:0] flags,
    output logic [3:0] bank_select_reg
);

    function automatic logic [11:0] file_address(input logic [7:0] f, input logic access_sel,
                                                 input logic ext_en, input logic [11:0] base,
                                                 input logic [3:0] bank);
        logic [11:0] addr;
        logic low_half;
        // the access bank maps f up to 0x5f to bank 0 (outside indexed mode) and f above 0x5f to the special bank
        low_half = (f <= `SRRE_INDEX_LIMIT);
        addr = 12'h000;
        if (access_sel) begin
            addr = {bank, f};
        end else if (ext_en && low_half) begin
            // the sum wraps at 12 bits; software keeps the index window in range
            addr = 12'(base + {4'h0, f});
        end else if (low_half) begin
            addr = {4'h0, f};
        end else begin
            addr = {`SRRE_SFR_BANK, f};
        end
        return addr;
    endfunction

    function automatic logic opcode_match(input logic [15:0] word, input logic [15:0] mask,
                                          input logic [15:0] code);
        return (word & mask) == code;
    endfunction

    // both returns pop the same way and give up the next slot as a pipeline nop
    function automatic srre_regs_s start_return(input srre_regs_s cur, input logic [20:0] top);
        srre_regs_s nxt;
        nxt = cur;
        nxt.stack_pop = 1'b1;
        nxt.pc_load = 1'b1;
        nxt.pc_target = top;
        nxt.fsm = SRRE_ST_NOP;
        return nxt;
    endfunction

    // reset copy: asserted with the pin, released two edges later
    logic rst_meta;
    logic rst_sync;
    // one struct holds every flop of the core except rst_meta and rst_sync; next_r is its combinational image
    srre_regs_s r;
    srre_regs_s next_r;

    logic is_ret;
    logic is_exit_with_literal_op;
    logic is_rlc;
    logic take;
    logic fast_restore;
    logic rot_to_file;
    // operand fields decoded once and shared by read address and write-back
    logic access_bit;
    logic [7:0] file_f;
    logic [7:0] rot_result;
    logic rot_carry;
    logic rot_neg;
    logic rot_zero;

    // reset asserts at once but releases only after two clean edges
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // file_raddr is combinational: the register file answers in the same cycle
    always_comb begin
        is_ret = opcode_match(instr_word, `SRRE_RET_MASK, `SRRE_RET_CODE);
        is_exit_with_literal_op = opcode_match(instr_word, `SRRE_EXIT_WITH_LITERAL_OP_MASK, `SRRE_EXIT_WITH_LITERAL_OP_CODE);
        is_rlc = opcode_match(instr_word, `SRRE_RLC_MASK, `SRRE_RLC_CODE);
        // a word is taken only when valid meets ready; the nop slot refuses it
        take = instr_valid && instr_ready;
        fast_restore = instr_word[`SRRE_FAST_BIT];
        rot_to_file = instr_word[`SRRE_DEST_BIT];
        access_bit = instr_word[`SRRE_ACCESS_BIT];
        file_f = instr_word[7:0];
        file_raddr = file_address(file_f, access_bit, ext_set_en, index_base, r.bank_select_reg);
    end

    // carry comes straight from the flag flop, so back-to-back rotates chain through it
    srre_rotate u_rotate (
        .operand(file_rdata),
        .carry_in(r.flags[`SRRE_FLAG_C]),
        .result(rot_result),
        .carry_out(rot_carry),
        .negative(rot_neg),
        .zero(rot_zero)
    );

    // ready drops for the slot after a return, whose fetched word is stale
    assign instr_ready = (r.fsm == SRRE_ST_EXEC);

    // pulse fields default low so each one lasts exactly one cycle
    always_comb begin
        next_r = r;
        next_r.stack_pop = 1'b0;
        next_r.pc_load = 1'b0;
        next_r.file_we = 1'b0;
        unique case (r.fsm)
            SRRE_ST_EXEC: begin
                if (take) begin
                    if (is_ret) begin
                        next_r = start_return(next_r, stack_top);
                        // clear fast bit keeps everything as is
                        if (fast_restore) begin
                            next_r.acc = accumulator_shadow;
                            next_r.flags = flags_shadow;
                            next_r.bank_select_reg = bank_select_shadow;
                        end
                    end else if (is_exit_with_literal_op) begin
                        next_r = start_return(next_r, stack_top);
                        next_r.acc = instr_word[7:0];
                    end else if (is_rlc) begin
                        // read and rotate in the accepting cycle; flags and acc load on its edge, the file write is strobed the cycle after
                        next_r.flags[`SRRE_FLAG_C] = rot_carry;
                        next_r.flags[`SRRE_FLAG_N] = rot_neg;
                        next_r.flags[`SRRE_FLAG_Z] = rot_zero;
                        // a cleared destination bit leaves the file alone and loads the accumulator
                        if (rot_to_file) begin
                            next_r.file_we = 1'b1;
                            next_r.file_waddr = file_raddr;
                            next_r.file_wdata = rot_result;
                        end else begin
                            next_r.acc = rot_result;
                        end
                    end
                    // other opcodes belong to other units and are simply taken
                end
            end
            SRRE_ST_NOP: begin
                // flushed slot: the fetched word after a return is discarded upstream
                // pulse fields were cleared above, so the slot drives nothing
                next_r.fsm = SRRE_ST_EXEC;
            end
            default: begin
                next_r.fsm = SRRE_ST_EXEC;
            end
        endcase
    end

    // constant image of the reset state keeps the reset branch a plain load
    localparam srre_regs_s regs_at_reset = '{
        fsm: SRRE_ST_EXEC,
        acc: `SRRE_ACC_RESET,
        flags: `SRRE_FLAGS_RESET,
        bank_select_reg: `SRRE_BANK_RESET,
        stack_pop: 1'b0,
        pc_load: 1'b0,
        pc_target: 21'h000000,
        file_we: 1'b0,
        file_waddr: 12'h000,
        file_wdata: 8'h00
    };

    always_ff @(posedge clock or negedge rst_sync) begin
        if (!rst_sync) begin
            r <= regs_at_reset;
        end else begin
            r <= next_r;
        end
    end

    // outputs come straight from flops of the state struct
    assign file_we = r.file_we;
    assign file_waddr = r.file_waddr;
    assign file_wdata = r.file_wdata;
    assign stack_pop = r.stack_pop;
    assign pc_load = r.pc_load;
    assign pc_target = r.pc_target;
    assign acc = r.acc;
    assign flags = r.flags;
    assign bank_select_reg = r.bank_select_reg;

endmodule

`default_nettype wire

// ---- rtl/srre_params.svh ----
`ifndef SRRE_PARAMS_SVH
`define SRRE_PARAMS_SVH

// opcode patterns, matched as (word & mask) == code
`define SRRE_RET_MASK 16'hfffe
`define SRRE_RET_CODE 16'h0012
`define SRRE_EXIT_WITH_LITERAL_OP_MASK 16'hff00
`define SRRE_EXIT_WITH_LITERAL_OP_CODE 16'h0c00
`define SRRE_RLC_MASK 16'hfc00
`define SRRE_RLC_CODE 16'h3400

// operand field positions
`define SRRE_FAST_BIT 0
`define SRRE_DEST_BIT 9
`define SRRE_ACCESS_BIT 8

// addressing
`define SRRE_INDEX_LIMIT 8'h5f
`define SRRE_SFR_BANK 4'hf

// flag positions inside the 5-bit flags register
`define SRRE_FLAG_C 0
`define SRRE_FLAG_DC 1
`define SRRE_FLAG_Z 2
`define SRRE_FLAG_OV 3
`define SRRE_FLAG_N 4

// reset values
`define SRRE_ACC_RESET 8'h00
`define SRRE_FLAGS_RESET 5'h00
`define SRRE_BANK_RESET 4'h0

`endif

// ---- rtl/srre_pkg.sv ----
package srre_pkg;

    typedef enum logic [1:0] {
        SRRE_ST_EXEC = 2'b01,
        SRRE_ST_NOP = 2'b10
    } srre_state_e;

    typedef struct packed {
        srre_state_e fsm;
        logic [7:0] acc;
        logic [4:0] flags;
        logic [3:0] bank_select_reg;
        logic stack_pop;
        logic pc_load;
        logic [20:0] pc_target;
        logic file_we;
        logic [11:0] file_waddr;
        logic [7:0] file_wdata;
    } srre_regs_s;

endpackage

// ---- rtl/srre_rotate.sv ----
`timescale 1ns/100ps
`default_nettype none

module srre_rotate (
    input wire logic [7:0] operand,
    input wire logic carry_in,
    output logic [7:0] result,
    output logic carry_out,
    output logic negative,
    output logic zero
);

    always_comb begin
        result = {operand[6:0], carry_in};
        carry_out = operand[7];
        negative = operand[6];
        zero = (operand[6:0] == 7'h00) && !carry_in;
    end

endmodule

`default_nettype wire

// ---- dv/srre_exec_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module srre_exec_props (
    input wire logic clock,
    input wire logic resetn,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [15:0] instr_word,
    input wire logic [20:0] stack_top,
    input wire logic [7:0] accumulator_shadow,
    input wire logic [4:0] flags_shadow,
    input wire logic [3:0] bank_select_shadow,
    input wire logic [7:0] file_rdata,
    input wire logic file_we,
    input wire logic [7:0] file_wdata,
    input wire logic stack_pop,
    input wire logic pc_load,
    input wire logic [20:0] pc_target,
    input wire logic [7:0] acc,
    input wire logic [4:0] flags,
    input wire logic [3:0] bank_select_reg
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    wire take = instr_valid && instr_ready;
    wire rlc = take && ((instr_word & 16'hfc00) == 16'h3400);
    wire ret = take && ((instr_word & 16'hfffe) == 16'h0012);
    wire lit = take && ((instr_word & 16'hff00) == 16'h0c00);
    property p_pop; ret |=> stack_pop && pc_load && pc_target == $past(stack_top); endproperty
    a_pop: assert property (p_pop) else $error("return did not load pc");
    property p_fast; ret && instr_word[0] |=> acc == $past(accumulator_shadow) && flags == $past(flags_shadow)
        && bank_select_reg == $past(bank_select_shadow); endproperty
    a_fast: assert property (p_fast) else $error("shadow restore wrong");
    property p_keep; ret && !instr_word[0] |=> $stable(acc) && $stable(flags) && $stable(bank_select_reg); endproperty
    a_keep: assert property (p_keep) else $error("plain return changed state");
    property p_rot; rlc |=> flags[0] == $past(file_rdata[7])
        && (file_we ? file_wdata : acc) == {$past(file_rdata[6:0]), $past(flags[0])}; endproperty
    a_rot: assert property (p_rot) else $error("rotate result wrong");
    property p_dest; rlc |=> file_we == $past(instr_word[9]); endproperty
    a_dest: assert property (p_dest) else $error("rotate target wrong");
    property p_nz; file_we |-> flags[4] == file_wdata[7] && flags[2] == (file_wdata == 8'h00); endproperty
    a_nz: assert property (p_nz) else $error("rotate flags wrong");
    property p_lit; lit |=> acc == $past(instr_word[7:0]) && stack_pop && $stable(flags); endproperty
    a_lit: assert property (p_lit) else $error("literal return wrong");
    property p_nop; ret || lit |=> !instr_ready ##1 instr_ready; endproperty
    a_nop: assert property (p_nop) else $error("return nop cycle wrong");
endmodule
bind srre_exec srre_exec_props srre_exec_props_i (.*);
`default_nettype wire

// ---- dv/srre_exec_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module srre_exec_tb;
    logic clock = 0, resetn = 0, instr_valid = 0, ext_set_en = 0;
    logic [15:0] instr_word = 0;
    logic [11:0] index_base = 0;
    logic [20:0] stack_top = 0;
    logic [7:0] accumulator_shadow = 0, file_rdata = 0, e_acc = 0;
    logic [4:0] flags_shadow = 0, e_flags = 0;
    logic [3:0] bank_select_shadow = 0, e_bsr = 0;
    wire instr_ready, file_we, stack_pop, pc_load;
    wire [11:0] file_raddr, file_waddr;
    wire [7:0] file_wdata, acc;
    wire [20:0] pc_target;
    wire [4:0] flags;
    wire [3:0] bank_select_reg;
    int error_cnt = 0;
    int cmp_count = 0;
    always #4 clock = ~clock;
    srre_exec srre_exec_i (.*);
    function automatic logic [11:0] addr_of(logic [15:0] w);
        if (w[8]) return {e_bsr, w[7:0]};
        if (w[7:0] > 8'h5f) return {4'hf, w[7:0]};
        return ext_set_en ? index_base + {4'h0, w[7:0]} : {4'h0, w[7:0]};
    endfunction
    task automatic give_verdict();
        $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    // one word per call; shadows and stack top change every call so stale copies show
    task automatic run(logic [15:0] w, logic [7:0] rd);
        logic [8:0] r;
        logic we;
        logic pop;
        logic [11:0] wa;
        r = {rd, e_flags[0]};
        we = 0;
        pop = 0;
        wa = 12'h000;
        instr_word = w;
        file_rdata = rd;
        stack_top = 21'($urandom);
        {accumulator_shadow, flags_shadow, bank_select_shadow} = 17'($urandom);
        ext_set_en = 1'($urandom);
        index_base = 12'($urandom);
        #1;
        if (w[15:10] == 6'h0d) begin
            wa = addr_of(w);
            check(file_raddr, wa);
            e_flags[0] = r[8];
            e_flags[4] = r[7];
            e_flags[2] = r[7:0] == 8'h00;
            if (w[9]) we = 1;
            else e_acc = r[7:0];
        end else if (w[15:1] == 15'h0009 || w[15:8] == 8'h0c) begin
            pop = 1;
            if (w[15:8] == 8'h0c) e_acc = w[7:0];
            else if (w[0]) {e_acc, e_flags, e_bsr} = {accumulator_shadow, flags_shadow, bank_select_shadow};
        end
        @(posedge clock);
        #1;
        check({acc, flags, bank_select_reg, stack_pop, pc_load, file_we}, {e_acc, e_flags, e_bsr, pop, pop, we});
        if (we) check({file_waddr, file_wdata}, {wa, r[7:0]});
        if (pop) begin
            check(pc_target, stack_top);
            check(instr_ready, 0);
            @(posedge clock);
            #1;
        end
    endtask
    initial begin
        logic [15:0] w;
        void'($urandom(26565));
        repeat (16) @(posedge clock);
        #1;
        resetn = 1;
        repeat (3) @(posedge clock);
        #1;
        // valid stays high: a return's nop cycle must hold the next word off by itself
        instr_valid = 1;
        run(16'h3600, 8'h80);
        run(16'h347f, 8'h7f);
        run(16'h0013, 8'h00);
        run(16'h3760, 8'h01);
        run(16'h345f, 8'hc3);
        run(16'h0012, 8'h00);
        run(16'h0c5a, 8'h00);
        // words of other classes are taken and must leave no trace
        run(16'h0011, 8'h3c);
        run(16'hf0a5, 8'hff);
        repeat (300) begin
            w = 16'($urandom);
            case ($urandom % 3)
                0: run({6'h0d, w[9:0]}, 8'($urandom));
                1: run({15'h0009, w[0]}, 8'h00);
                default: run({8'h0c, w[7:0]}, 8'h00);
            endcase
        end
        give_verdict();
    end
    initial begin
        #50000;
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
